/* File: design/pio_port.sv */
/*
  pio_port: one 16-pin general purpose port with direction, latch,
  open-drain, analog select, weak pulls and change notification.
  assumes: synchronous pin inputs, a simple strobe register port with read
  data one cycle later, pads resolve out/oe/pull signals outside.
*/
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// - direction bit one makes pin input; zero drives the latch out
// - after reset every direction bit is one, all pins inputs
// - latch read returns latch contents; latch write updates latch
// - port read returns pin levels; port write updates the latch
// - open-drain bit makes the pin drive low only, else release
// - peripheral drive and peripheral input only while analog select bit clear
// - analog select register resets to all ones
// - output with analog select set still drives digital level
// - port read gives zero for pins that are analog inputs
// - an active peripheral owns the pin, not the gpio latch
// - change detection works with the clock stopped in sleep
// - per-pin change enable lets a change raise an interrupt request
// - change status bit records change since last port read
// - separate weak pull-up and pull-down enable per pin
// - clear, set, invert aliases touch only bits written as one
// - alias reads return undefined; base register shows result
module pio_port #(
  parameter int WIDTH = 16
) (
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  input  wire logic             clk_en,
  input  wire logic [7:0]       reg_addr,
  input  wire logic [31:0]      reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [31:0]      reg_rdata,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_out,
  output logic      [WIDTH-1:0] pin_oe,
  output logic      [WIDTH-1:0] pull_up_en,
  output logic      [WIDTH-1:0] pull_down_en,
  output logic      [WIDTH-1:0] analog_en,
  input  wire logic [WIDTH-1:0] peri_out,
  input  wire logic [WIDTH-1:0] peri_oe,
  output logic      [WIDTH-1:0] peri_in,
  output logic                  change_irq
);

  // ****************************************************************
  // register state
  // ****************************************************************
  logic [WIDTH-1:0] direction_control_ff;
  logic [WIDTH-1:0] output_latch_ff;
  logic [WIDTH-1:0] open_drain_control_ff;
  logic [WIDTH-1:0] analog_select_register_ff;
  logic [WIDTH-1:0] change_notice_enable_ff;
  logic [WIDTH-1:0] change_notice_status_ff;
  logic [WIDTH-1:0] weak_pullup_enable_ff;
  logic [WIDTH-1:0] weak_pulldown_enable_ff;
  logic [WIDTH-1:0] peri_own_ff;
  logic [WIDTH-1:0] last_read_level_ff;
  logic [31:0]      rdata_ff;

  // ****************************************************************
  // address decode
  // ****************************************************************
  wire logic [3:0] grp_sel   = reg_addr[7:4];
  wire logic [1:0] alias_sel = reg_addr[3:2];
  wire logic       word_ok   = (reg_addr[1:0] == 2'h0);
  wire logic       wr_ok     = reg_wr & clk_en & word_ok;
  wire logic       rd_ok     = reg_rd & clk_en;

  // address group compare; operands come in as arguments so that the
  // continuous assignments below follow every change of the address
  function automatic logic hit(input logic [3:0] grp, input logic [7:0] ofs);
    hit = (grp == ofs[7:4]);
  endfunction : hit

  // alias arithmetic applied to a base value
  function automatic logic [WIDTH-1:0] alias_apply(
    input logic [WIDTH-1:0] cur,
    input logic [1:0]       kind,
    input logic [WIDTH-1:0] val
  );
    unique case (kind)
      pio_pkg::PIO_ALIAS_BASE: alias_apply = val;
      pio_pkg::PIO_ALIAS_CLR:  alias_apply = cur & ~val;
      pio_pkg::PIO_ALIAS_SET:  alias_apply = cur | val;
      pio_pkg::PIO_ALIAS_INV:  alias_apply = cur ^ val;
    endcase
  endfunction : alias_apply

  wire logic [WIDTH-1:0] wval = reg_wdata[WIDTH-1:0];

  // ****************************************************************
  // per-register write strobes
  // ****************************************************************
  wire logic wr_dir  = wr_ok & hit(grp_sel, pio_pkg::PIO_DIR_OFS);
  // port and latch writes both land in the latch
  wire logic wr_lat  = wr_ok & (hit(grp_sel, pio_pkg::PIO_LAT_OFS)
                                | hit(grp_sel, pio_pkg::PIO_LVL_OFS));
  wire logic wr_odc  = wr_ok & hit(grp_sel, pio_pkg::PIO_ODC_OFS);
  wire logic wr_ana  = wr_ok & hit(grp_sel, pio_pkg::PIO_ANA_OFS);
  wire logic wr_cne  = wr_ok & hit(grp_sel, pio_pkg::PIO_CNE_OFS);
  wire logic wr_cns  = wr_ok & hit(grp_sel, pio_pkg::PIO_CNS_OFS);
  wire logic wr_pu   = wr_ok & hit(grp_sel, pio_pkg::PIO_PU_OFS);
  wire logic wr_pd   = wr_ok & hit(grp_sel, pio_pkg::PIO_PD_OFS);
  wire logic wr_peri = wr_ok & hit(grp_sel, pio_pkg::PIO_PERI_OFS);

  // ****************************************************************
  // pin level sampling and digital view
  // ****************************************************************
  // analog input channels read as zero
  wire logic [WIDTH-1:0] analog_input = analog_select_register_ff & direction_control_ff;
  wire logic [WIDTH-1:0] level_view   = pin_in & ~analog_input;
  wire logic             lvl_base_rd  = rd_ok && grp_sel == pio_pkg::PIO_LVL_OFS[7:4]
                                        && alias_sel == pio_pkg::PIO_ALIAS_BASE;

  // ****************************************************************
  // change notification
  // ****************************************************************
  // level compare is combinational so a wake-up needs no clock edge
  wire logic [WIDTH-1:0] pin_differs = (pin_in ^ last_read_level_ff) & change_notice_enable_ff;
  wire logic [WIDTH-1:0] cns_view    = change_notice_status_ff | pin_differs;

  // a port read recaptures the level, so no change is pending right after it;
  // a live difference still wins over a software clear through the aliases
  wire logic [WIDTH-1:0] cns_pend = lvl_base_rd ? {WIDTH{1'b0}}
                                    : (change_notice_status_ff | pin_differs);
  wire logic [WIDTH-1:0] nxt_cns  = wr_cns
                                    ? (alias_apply(change_notice_status_ff, alias_sel, wval) | pin_differs)
                                    : cns_pend;

  // irq is a pure level so it works while the clock is stopped
  assign change_irq = |(cns_view & change_notice_enable_ff);

  // ****************************************************************
  // pad drive
  // ****************************************************************
  // gpio output enable: output direction, open drain releases on one
  wire logic [WIDTH-1:0] gpio_oe  = ~direction_control_ff
                                    & ~(open_drain_control_ff & output_latch_ff);
  wire logic [WIDTH-1:0] gpio_out = output_latch_ff & ~open_drain_control_ff;
  // peripherals may take a pin only when it is digital
  wire logic [WIDTH-1:0] peri_take = peri_own_ff & ~analog_select_register_ff;

  assign pin_oe       = (peri_take & peri_oe) | (~peri_take & gpio_oe);
  assign pin_out      = (peri_take & peri_out) | (~peri_take & gpio_out);
  assign peri_in      = pin_in & ~analog_select_register_ff;
  assign pull_up_en   = weak_pullup_enable_ff;
  assign pull_down_en = weak_pulldown_enable_ff;
  assign analog_en    = analog_select_register_ff;
  assign reg_rdata    = rdata_ff;

  // ****************************************************************
  // read mux
  // ****************************************************************
  logic [WIDTH-1:0] rd_word;
  always_comb
  begin
    rd_word = {WIDTH{1'b0}};
    unique case (grp_sel)
      pio_pkg::PIO_DIR_OFS[7:4]:  rd_word = direction_control_ff;
      pio_pkg::PIO_LVL_OFS[7:4]:  rd_word = level_view;
      pio_pkg::PIO_LAT_OFS[7:4]:  rd_word = output_latch_ff;
      pio_pkg::PIO_ODC_OFS[7:4]:  rd_word = open_drain_control_ff;
      pio_pkg::PIO_ANA_OFS[7:4]:  rd_word = analog_select_register_ff;
      pio_pkg::PIO_CNE_OFS[7:4]:  rd_word = change_notice_enable_ff;
      pio_pkg::PIO_CNS_OFS[7:4]:  rd_word = cns_view;
      pio_pkg::PIO_PU_OFS[7:4]:   rd_word = weak_pullup_enable_ff;
      pio_pkg::PIO_PD_OFS[7:4]:   rd_word = weak_pulldown_enable_ff;
      pio_pkg::PIO_PERI_OFS[7:4]: rd_word = peri_own_ff;
      default:                    rd_word = {WIDTH{1'b0}};
    endcase
  end

  // aliases read the fixed undefined pattern
  wire logic [31:0] nxt_rdata = (alias_sel != pio_pkg::PIO_ALIAS_BASE)
                                ? pio_pkg::PIO_UNDEF_RD
                                : {{(32-WIDTH){1'b0}}, rd_word};

  // ****************************************************************
  // register updates
  // ****************************************************************
  // configuration registers
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      direction_control_ff      <= pio_pkg::PIO_DIR_RST;
      analog_select_register_ff <= pio_pkg::PIO_ANA_RST;
      output_latch_ff           <= pio_pkg::PIO_ZERO_RST;
      open_drain_control_ff     <= pio_pkg::PIO_ZERO_RST;
      change_notice_enable_ff   <= pio_pkg::PIO_ZERO_RST;
      weak_pullup_enable_ff     <= pio_pkg::PIO_ZERO_RST;
      weak_pulldown_enable_ff   <= pio_pkg::PIO_ZERO_RST;
      peri_own_ff               <= pio_pkg::PIO_ZERO_RST;
    end
    else
    begin
      if (wr_dir)
        direction_control_ff <= alias_apply(direction_control_ff, alias_sel, wval);
      if (wr_lat)
        output_latch_ff <= alias_apply(output_latch_ff, alias_sel, wval);
      if (wr_odc)
        open_drain_control_ff <= alias_apply(open_drain_control_ff, alias_sel, wval);
      if (wr_ana)
        analog_select_register_ff <= alias_apply(analog_select_register_ff, alias_sel, wval);
      if (wr_cne)
        change_notice_enable_ff <= alias_apply(change_notice_enable_ff, alias_sel, wval);
      if (wr_pu)
        weak_pullup_enable_ff <= alias_apply(weak_pullup_enable_ff, alias_sel, wval);
      if (wr_pd)
        weak_pulldown_enable_ff <= alias_apply(weak_pulldown_enable_ff, alias_sel, wval);
      if (wr_peri)
        peri_own_ff <= alias_apply(peri_own_ff, alias_sel, wval);
    end
  end

  // change status, captured level and read data
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      change_notice_status_ff <= pio_pkg::PIO_ZERO_RST;
      last_read_level_ff      <= pio_pkg::PIO_ZERO_RST;
      rdata_ff                <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
      change_notice_status_ff <= nxt_cns;
      if (lvl_base_rd)
        last_read_level_ff <= pin_in;
      if (rd_ok)
        rdata_ff <= nxt_rdata;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  // reset leaves every gpio pin undriven and every analog pin analog
  a_dir_reset_input: assert property (@(posedge core_clk)
    $fell(sys_rst) |-> (pin_oe & ~peri_take) == {WIDTH{1'b0}})
    else $error("pin driven by gpio right after reset");

  a_ana_reset_ones: assert property (@(posedge core_clk)
    $fell(sys_rst) |-> analog_en == {WIDTH{1'b1}})
    else $error("analog select not all ones after reset");

  // a latch write followed at once by a latch read returns the written word
  sequence s_lat_write;
    wr_ok && grp_sel == pio_pkg::PIO_LAT_OFS[7:4] && alias_sel == pio_pkg::PIO_ALIAS_BASE;
  endsequence : s_lat_write

  sequence s_lat_read;
    rd_ok && !reg_wr && grp_sel == pio_pkg::PIO_LAT_OFS[7:4] && alias_sel == pio_pkg::PIO_ALIAS_BASE;
  endsequence : s_lat_read

  a_lat_write_read: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_lat_write ##1 s_lat_read |=> reg_rdata[WIDTH-1:0] == $past(wval, 2))
    else $error("latch read does not return written value");

  a_port_write_latch: assert property (@(posedge core_clk) disable iff (sys_rst)
    (wr_ok && grp_sel == pio_pkg::PIO_LVL_OFS[7:4] && alias_sel == pio_pkg::PIO_ALIAS_BASE)
    |=> output_latch_ff == $past(wval))
    else $error("port write did not reach the latch");

  a_dir_write_lands: assert property (@(posedge core_clk) disable iff (sys_rst)
    (wr_dir && alias_sel == pio_pkg::PIO_ALIAS_BASE) |=> direction_control_ff == $past(wval))
    else $error("direction write lost");

  a_port_analog_zero: assert property (@(posedge core_clk) disable iff (sys_rst)
    lvl_base_rd |=> (reg_rdata[WIDTH-1:0] & $past(analog_input)) == {WIDTH{1'b0}})
    else $error("analog input pin read nonzero");

  // pad drive: open drain, push-pull and peripheral ownership
  a_open_drain_high: assert property (@(posedge core_clk) disable iff (sys_rst)
    ((open_drain_control_ff & ~peri_take & pin_oe) & pin_out) == {WIDTH{1'b0}})
    else $error("open drain pin driven high");

  a_gpio_out_follows: assert property (@(posedge core_clk) disable iff (sys_rst)
    ((~direction_control_ff & ~open_drain_control_ff & ~peri_take)
     & ~(pin_oe & ~(pin_out ^ output_latch_ff))) == {WIDTH{1'b0}})
    else $error("output pin not driving the latch");

  a_peri_owns_pin: assert property (@(posedge core_clk) disable iff (sys_rst)
    (peri_take & (pin_oe ^ peri_oe)) == {WIDTH{1'b0}})
    else $error("peripheral lost control of its pin");

  a_peri_in_analog: assert property (@(posedge core_clk) disable iff (sys_rst)
    (peri_in & analog_en) == {WIDTH{1'b0}})
    else $error("digital input seen on an analog pin");

  // change status: set by a difference, cleared by a port read
  a_cns_set_change: assert property (@(posedge core_clk) disable iff (sys_rst)
    (clk_en && !lvl_base_rd && |pin_differs)
    |=> (change_notice_status_ff & $past(pin_differs)) == $past(pin_differs))
    else $error("change not recorded in status");

  a_cns_read_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
    (lvl_base_rd && !reg_wr) |=> change_notice_status_ff == {WIDTH{1'b0}})
    else $error("port read left change status set");

  a_lvl_capture: assert property (@(posedge core_clk) disable iff (sys_rst)
    lvl_base_rd |=> last_read_level_ff == $past(pin_in))
    else $error("port read did not capture the pin level");

  a_irq_level: assert property (@(posedge core_clk) disable iff (sys_rst)
    (|(change_notice_status_ff & change_notice_enable_ff)) |-> change_irq)
    else $error("enabled status bit raised no request");

  a_irq_clockless: assert property (@(posedge core_clk) disable iff (sys_rst)
    (|pin_differs) |-> change_irq)
    else $error("live change on enabled pin raised no request");

  a_irq_needs_enable: assert property (@(posedge core_clk) disable iff (sys_rst)
    change_irq |-> (change_notice_enable_ff != {WIDTH{1'b0}}))
    else $error("request raised with no pin enabled");

  // alias writes touch only the bits written as one
  a_alias_set_only: assert property (@(posedge core_clk) disable iff (sys_rst)
    (wr_ok && grp_sel == pio_pkg::PIO_ODC_OFS[7:4] && alias_sel == pio_pkg::PIO_ALIAS_SET)
    |=> open_drain_control_ff == ($past(open_drain_control_ff) | $past(wval)))
    else $error("set alias changed bits written as zero");

  a_alias_clr_only: assert property (@(posedge core_clk) disable iff (sys_rst)
    (wr_lat && alias_sel == pio_pkg::PIO_ALIAS_CLR)
    |=> output_latch_ff == ($past(output_latch_ff) & ~$past(wval)))
    else $error("clear alias changed bits written as zero");

  a_alias_read_undef: assert property (@(posedge core_clk) disable iff (sys_rst)
    (rd_ok && alias_sel != pio_pkg::PIO_ALIAS_BASE) |=> reg_rdata == pio_pkg::PIO_UNDEF_RD)
    else $error("alias read did not return the fixed pattern");

  // a low clock enable freezes the registers
  a_freeze_holds: assert property (@(posedge core_clk) disable iff (sys_rst)
    !clk_en |=> $stable(change_notice_status_ff) && $stable(direction_control_ff))
    else $error("state moved while the clock enable was low");

endmodule : pio_port

`default_nettype wire

/* File: inc/pio_pkg.sv */
/*
  pio_pkg: register offsets, reset values and alias kinds for the parallel
  i/o port with change notice.
  assumes: included before any design file; no timescale here.
*/
`default_nettype none

package pio_pkg;

  // ****************************************************************
  // register word offsets (byte address = offset)
  // ****************************************************************
  localparam logic [7:0] PIO_DIR_OFS   = 8'h00; // direction_control
  localparam logic [7:0] PIO_LVL_OFS   = 8'h10; // pin_level_register
  localparam logic [7:0] PIO_LAT_OFS   = 8'h20; // output_latch
  localparam logic [7:0] PIO_ODC_OFS   = 8'h30; // open_drain_control
  localparam logic [7:0] PIO_ANA_OFS   = 8'h40; // analog_select_register
  localparam logic [7:0] PIO_CNE_OFS   = 8'h50; // change_notice_enable
  localparam logic [7:0] PIO_CNS_OFS   = 8'h60; // change_notice_status
  localparam logic [7:0] PIO_PU_OFS    = 8'h70; // weak_pullup_enable
  localparam logic [7:0] PIO_PD_OFS    = 8'h80; // weak_pulldown_enable
  localparam logic [7:0] PIO_PERI_OFS  = 8'h90; // peripheral ownership

  // ****************************************************************
  // alias words inside each 16-byte group: base, clear, set, invert
  // ****************************************************************
  localparam logic [1:0] PIO_ALIAS_BASE = 2'h0;
  localparam logic [1:0] PIO_ALIAS_CLR  = 2'h1;
  localparam logic [1:0] PIO_ALIAS_SET  = 2'h2;
  localparam logic [1:0] PIO_ALIAS_INV  = 2'h3;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [15:0] PIO_DIR_RST  = 16'hFFFF;
  localparam logic [15:0] PIO_ANA_RST  = 16'hFFFF;
  localparam logic [15:0] PIO_ZERO_RST = 16'h0000;
  localparam logic [31:0] PIO_UNDEF_RD = 32'h0000_0000; // alias reads

endpackage : pio_pkg

`default_nettype wire

/* File: tb/pio_pad_model.sv */
/*
  pio_pad_model: the pads and the external devices on the port pins.
  assumes: pin_out/pin_oe from the port, ext_val/ext_oe from the bench.
*/
`timescale 1ns/1ns
`default_nettype none

module pio_pad_model #(
  parameter int WIDTH = 16
) (
  input  wire logic             core_clk,
  input  wire logic [WIDTH-1:0] pin_out,
  input  wire logic [WIDTH-1:0] pin_oe,
  input  wire logic [WIDTH-1:0] pull_up_en,
  input  wire logic [WIDTH-1:0] pull_down_en,
  input  wire logic [WIDTH-1:0] ext_val,
  input  wire logic [WIDTH-1:0] ext_oe,
  output logic      [WIDTH-1:0] pin_lvl
);
  logic [WIDTH-1:0] last_ff = '0;

  // pins that something holds; the others float
  wire logic [WIDTH-1:0] held = pin_oe | ext_oe | pull_up_en | pull_down_en;

  // port drive wins, then the device, then weak pulls; a floating pin
  // shows the inverse of the level it was last held at
  always_comb
  begin
    for (int i = 0; i < WIDTH; i++)
    begin
      if (pin_oe[i]) pin_lvl[i] = pin_out[i];
      else if (ext_oe[i]) pin_lvl[i] = ext_val[i];
      else if (pull_up_en[i]) pin_lvl[i] = 1'b1;
      else if (pull_down_en[i]) pin_lvl[i] = 1'b0;
      else pin_lvl[i] = ~last_ff[i];
    end
  end

  // last held level of each pin, used for the floating pattern
  always_ff @(posedge core_clk)
  begin
    last_ff <= (held & pin_lvl) | (~held & last_ff);
  end
endmodule : pio_pad_model

`default_nettype wire

/* File: tb/tb_pio_port.sv */
/*
  tb_pio_port: self-checking bench for the parallel port with change notice.
  assumes: pio_pkg compiled first; pio_pad_model stands in for the pins.
*/
`timescale 1ns/1ns
`default_nettype none

module tb_pio_port;
  logic core_clk, sys_rst, clk_en, reg_wr, reg_rd, change_irq;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [15:0] pin_in, pin_out, pin_oe, pull_up_en, pull_down_en, analog_en;
  logic [15:0] peri_out, peri_oe, peri_in, ext_val, ext_oe;
  int          err_total = 0;
  int          samples_checked = 0;

  pio_port #(.WIDTH(16)) pio_port_inst (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pull_up_en(pull_up_en),
    .pull_down_en(pull_down_en), .analog_en(analog_en), .peri_out(peri_out), .peri_oe(peri_oe),
    .peri_in(peri_in), .change_irq(change_irq));
  pio_pad_model #(.WIDTH(16)) pio_pad_model_inst (.core_clk(core_clk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pull_up_en(pull_up_en), .pull_down_en(pull_down_en), .ext_val(ext_val), .ext_oe(ext_oe),
    .pin_lvl(pin_in));

  // ****************************************************************
  // clock, shared tasks
  // ****************************************************************
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic conclude();
    if (err_total == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t %s: seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : chk

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : idle

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= {16'h0000, d};
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string msg);
    logic [31:0] d;
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
    chk(d, exp, msg);
  endtask : rdchk

  task automatic wr_rd(input logic [7:0] a, input logic [15:0] d, input string msg);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= {16'h0000, d};
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
    reg_rd    <= 1'b1;
    @(posedge core_clk);
    reg_rd    <= 1'b0;
    #1;
    chk(reg_rdata, {16'h0000, d}, msg);
  endtask : wr_rd

  task automatic pins(input logic [15:0] v, input logic [15:0] oe);
    @(posedge core_clk);
    ext_val <= v;
    ext_oe  <= oe;
    idle(2);
  endtask : pins

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    chk(32'(pin_oe | pull_up_en | pull_down_en), 32'h0, "reset drives");
    rdchk(pio_pkg::PIO_DIR_OFS, 32'h0000FFFF, "dir reset");
    rdchk(pio_pkg::PIO_ANA_OFS, 32'h0000FFFF, "analog reset");
    rdchk(8'hA0, 32'h0, "unmapped read");
  endtask : t_reset

  task automatic t_latch_port();
    wr_rd(pio_pkg::PIO_LAT_OFS, 16'h1234, "latch read");
    wr(pio_pkg::PIO_ANA_OFS, 16'h0000);
    pins(16'hA5C3, 16'hFFFF);
    rdchk(pio_pkg::PIO_LVL_OFS, 32'hA5C3, "port reads pins");
    wr(pio_pkg::PIO_LVL_OFS, 16'h01EF);
    rdchk(pio_pkg::PIO_LAT_OFS, 32'h01EF, "port write to latch");
    chk(32'(pin_oe), 32'h0, "inputs undriven");
    pins(16'hA5C3, 16'hFF00);
    wr(pio_pkg::PIO_DIR_OFS, 16'hFF00);
    idle(2);
    chk(32'(pin_oe), 32'h00FF, "outputs driven");
    rdchk(pio_pkg::PIO_LVL_OFS, 32'hA5EF, "mixed port read");
  endtask : t_latch_port

  task automatic t_alias();
    wr(pio_pkg::PIO_LAT_OFS, 16'h00F0);
    wr(pio_pkg::PIO_LAT_OFS | 8'h08, 16'h000F);
    wr(pio_pkg::PIO_LAT_OFS | 8'h04, 16'h0011);
    wr(pio_pkg::PIO_LAT_OFS | 8'h0C, 16'h0101);
    rdchk(pio_pkg::PIO_LAT_OFS, 32'h01EF, "set clr inv");
    rdchk(pio_pkg::PIO_LAT_OFS | 8'h08, pio_pkg::PIO_UNDEF_RD, "alias");
  endtask : t_alias

  task automatic t_open_drain();
    wr(pio_pkg::PIO_LAT_OFS, 16'h00EF);
    wr(pio_pkg::PIO_ODC_OFS | 8'h08, 16'h0011);
    idle(1);
    chk(32'(pin_oe & 16'h0011), 32'h0010, "od enables");
    chk(32'(pin_out & 16'h0010), 32'h0, "od drives low");
    wr(pio_pkg::PIO_ODC_OFS, 16'h0000);
    idle(1);
    chk(32'(pin_oe & 16'h0011), 32'h0011, "push pull back");
  endtask : t_open_drain

  task automatic t_analog();
    wr(pio_pkg::PIO_ANA_OFS, 16'h000F);
    idle(1);
    chk(32'(pin_oe & pin_out & 16'h000F), 32'h000F, "analog output");
    wr(pio_pkg::PIO_DIR_OFS, 16'hFFFF);
    pins(16'hFFFF, 16'hFFFF);
    rdchk(pio_pkg::PIO_LVL_OFS, 32'hFFF0, "analog reads zero");
    chk(32'(analog_en), 32'h000F, "analog select out");
    chk(32'(peri_in), 32'hFFF0, "digital blocked");
  endtask : t_analog

  task automatic t_periph();
    wr(pio_pkg::PIO_ANA_OFS, 16'h0001);
    wr(pio_pkg::PIO_PERI_OFS, 16'h0003);
    @(posedge core_clk);
    peri_oe  <= 16'h0003;
    peri_out <= 16'h0000;
    pins(16'hFFFF, 16'hFFFC);
    chk(32'(pin_oe & 16'h0003), 32'h0002, "peripheral owns");
    chk(32'(pin_out & 16'h0002), 32'h0, "peripheral level");
    wr(pio_pkg::PIO_PERI_OFS, 16'h0000);
    @(posedge core_clk);
    peri_oe  <= 16'h0000;
  endtask : t_periph

  task automatic t_pulls();
    wr(pio_pkg::PIO_PU_OFS, 16'h00F0);
    wr(pio_pkg::PIO_PD_OFS, 16'h0F00);
    pins(16'hFFFF, 16'hF00F);
    chk({pull_up_en, pull_down_en}, 32'h00F00F00, "pull enables");
    rdchk(pio_pkg::PIO_LVL_OFS, 32'hF0FE, "pulled levels");
  endtask : t_pulls

  task automatic t_change();
    pins(16'h0000, 16'hFFFF);
    rdchk(pio_pkg::PIO_LVL_OFS, 32'h0, "capture");
    wr(pio_pkg::PIO_CNE_OFS, 16'h0030);
    pins(16'h0100, 16'hFFFF);
    chk(32'(change_irq), 32'h0, "disabled pin quiet");
    pins(16'h0110, 16'hFFFF);
    chk(32'(change_irq), 32'h1, "enabled change");
    pins(16'h0100, 16'hFFFF);
    rdchk(pio_pkg::PIO_CNS_OFS, 32'h0010, "status kept");
    rdchk(pio_pkg::PIO_LVL_OFS, 32'h0100, "port read");
    idle(1);
    chk(32'(change_irq), 32'h0, "status cleared");
    @(posedge core_clk);
    clk_en  <= 1'b0;
    ext_val <= 16'h0120;
    #5;
    chk(32'(change_irq), 32'h1, "change while frozen");
    @(posedge core_clk);
    clk_en  <= 1'b1;
    rdchk(pio_pkg::PIO_LVL_OFS, 32'h0120, "read while changed");
    idle(1);
    chk(32'(change_irq), 32'h0, "read clears status");
  endtask : t_change

  // ****************************************************************
  // main sequence and watchdog
  // ****************************************************************
  initial
  begin
    sys_rst = 1'b1;
    clk_en = 1'b1;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    {peri_out, peri_oe, ext_val} = '0;
    ext_oe = 16'hFFFF;
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b0;
    idle(1);
    t_reset();
    t_latch_port();
    t_alias();
    t_open_drain();
    t_analog();
    t_periph();
    t_pulls();
    t_change();
    conclude();
  end

  initial
  begin
    repeat (3000) @(posedge core_clk);
    err_total++;
    conclude();
  end
endmodule : tb_pio_port

`default_nettype wire
